// ### design/pdn_params.svh
// Constants for the port direction negotiation block
`ifndef PDN_PARAMS_SVH
`define PDN_PARAMS_SVH

// Number of slow ports and their width
`define PDN_NUM_PORTS 4
`define PDN_PORT_W 8

// Bit positions in the direction pattern
`define PDN_DIR_A_BIT 0
`define PDN_DIR_B_BIT 1
`define PDN_DIR_C_BIT 2
`define PDN_DIR_D_BIT 3
`define PDN_DIR_FAST_BIT 4
`define PDN_DIR_W 5

// Low means output in the direction pattern
`define PDN_DIR_OUT 1'b0

// Reset values
`define PDN_RST_DIR 5'h1F
`define PDN_RST_VAL 32'h0000_0000
`define PDN_RST_REL 4'h0
`define PDN_PIN_IDLE 8'hFF

// Release masks
`define PDN_REL_MASK_NONE 4'h0
`define PDN_REL_MASK_A 4'h1
`define PDN_REL_MASK_ALL 4'hF

// Read selects
`define PDN_RD_SEL_W 2

`endif

// ### design/pdn_pkg.sv
// Types shared by the port direction negotiation block
package pdn_pkg;

   // Tristate release carried by a configuration command
   typedef enum logic [1:0] {
      PDN_REL_KEEP,
      PDN_REL_NONE,
      PDN_REL_A_ONLY,
      PDN_REL_ALL
   } pdn_rel_e;

endpackage

// ### design/pdn_port_if.sv
// Carrier between the control logic and one port slice
`timescale 1ns/1ps
interface pdn_port_if;
   logic [7:0] val;
   logic is_out;
   logic released;
   logic [7:0] sampled;

   modport ctl (
      output val,
      output is_out,
      output released,
      input sampled
   );

   modport slice (
      input val,
      input is_out,
      input released,
      output sampled
   );
endinterface

// ### design/pdn_port_slice.sv
// One 8-bit port: pin synchroniser and tristate driver
`timescale 1ns/1ps
`include "pdn_params.svh"
module pdn_port_slice (
   // Clock and reset
   input logic mclk,
   input logic rst,
   // Control side
   pdn_port_if.slice p,
   // Pins
   input logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe
);
   import pdn_pkg::*;

   logic [7:0] meta_q;
   logic [7:0] meta_d;
   logic [7:0] sync_q;
   logic [7:0] sync_d;

   // Two stages; only the second stage is read by the block
   always_comb begin
      meta_d = pin_in;
      sync_d = meta_q;
   end

   // Idle level is the pulled-up high of an undriven line
   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_q <= `PDN_PIN_IDLE;
         sync_q <= `PDN_PIN_IDLE;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign p.sampled = sync_q;

   // An input port drops its output value and never drives
   assign pin_out = p.is_out ? p.val : 8'h00;
   assign pin_oe = {8{p.released & p.is_out}};
endmodule

// ### design/pdn_top.sv
// Port direction control for the four slow ports
`timescale 1ns/1ps
`include "pdn_params.svh"
module pdn_top (
   // Clock and reset
   input logic mclk,
   input logic rst,
   // Configuration command
   input logic cmd_valid,
   input logic [4:0] cmd_dir,
   input logic [31:0] cmd_init,
   input pdn_pkg::pdn_rel_e cmd_release,
   output logic cmd_done,
   output logic cmd_cd_forced,
   // Port read
   input logic rd_valid,
   input logic rd_all,
   input logic [1:0] rd_sel,
   output logic rd_ack,
   output logic [31:0] rd_data,
   // Status
   output logic [4:0] port_dir,
   output logic [3:0] port_released,
   output logic fast_dir,
   // Port A pins
   input logic [7:0] pa_in,
   output logic [7:0] pa_out,
   output logic [7:0] pa_oe,
   // Port B pins
   input logic [7:0] pb_in,
   output logic [7:0] pb_out,
   output logic [7:0] pb_oe,
   // Port C pins
   input logic [7:0] pc_in,
   output logic [7:0] pc_out,
   output logic [7:0] pc_oe,
   // Port D pins
   input logic [7:0] pd_in,
   output logic [7:0] pd_out,
   output logic [7:0] pd_oe
);
   import pdn_pkg::*;

   // Configuration state
   logic [4:0] dir_q;
   logic [4:0] dir_d;
   logic [31:0] val_q;
   logic [31:0] val_d;
   logic [3:0] rel_q;
   logic [3:0] rel_d;

   // Command events
   logic done_q;
   logic done_d;
   logic forced_q;
   logic forced_d;

   // Read state
   logic ack_q;
   logic ack_d;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;

   // Pins gathered for the slice loop
   logic [7:0] pin_in_w [4];
   logic [7:0] pin_out_w [4];
   logic [7:0] pin_oe_w [4];
   logic [7:0] sampled_w [4];

   // C/D override terms
   logic c_dir_req;
   logic d_dir_req;
   logic c_dir_eff;
   logic cd_clash;

   // One carrier per port, indexed like the pattern bits
   pdn_port_if port_if [4] ();

   // Port C is set opposite to D when both ask for the same direction
   assign c_dir_req = cmd_dir[`PDN_DIR_C_BIT];
   assign d_dir_req = cmd_dir[`PDN_DIR_D_BIT];
   assign cd_clash = (c_dir_req == d_dir_req);
   assign c_dir_eff = cd_clash ? ~d_dir_req : c_dir_req;

   // KEEP lets software reload values without touching tristate
   // Configuration group
   always_comb begin
      dir_d = dir_q;
      val_d = val_q;
      rel_d = rel_q;
      if (cmd_valid) begin
         // Directions, values and release all change in one step
         dir_d = cmd_dir;
         dir_d[`PDN_DIR_C_BIT] = c_dir_eff;
         val_d = cmd_init;
         // No mask form exists that frees B, C or D without the rest
         case (cmd_release)
            PDN_REL_KEEP: rel_d = rel_q;
            PDN_REL_NONE: rel_d = `PDN_REL_MASK_NONE;
            PDN_REL_A_ONLY: rel_d = `PDN_REL_MASK_A;
            PDN_REL_ALL: rel_d = `PDN_REL_MASK_ALL;
            default: rel_d = `PDN_REL_MASK_NONE;
         endcase
      end
   end

   // Values are cleared too, so a later release never drives stale data
   // Reset leaves every port tristated and set as input
   always_ff @(posedge mclk) begin
      if (rst) begin
         dir_q <= `PDN_RST_DIR;
         val_q <= `PDN_RST_VAL;
         rel_q <= `PDN_RST_REL;
      end else begin
         dir_q <= dir_d;
         val_q <= val_d;
         rel_q <= rel_d;
      end
   end

   // Both events are pulses; software watches done, not a level
   // Command event group
   always_comb begin
      done_d = cmd_valid;
      forced_d = cmd_valid & cd_clash;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         done_q <= 1'b0;
         forced_q <= 1'b0;
      end else begin
         done_q <= done_d;
         forced_q <= forced_d;
      end
   end

   // Pins reach a read three edges late: two sync stages and the read
   // Read group; a read sees the pins whatever the direction
   always_comb begin
      ack_d = rd_valid;
      rdat_d = rdat_q;
      if (rd_valid) begin
         if (rd_all) begin
            rdat_d = {sampled_w[3], sampled_w[2], sampled_w[1], sampled_w[0]};
         end else begin
            rdat_d = {24'h00_0000, sampled_w[rd_sel]};
         end
      end
   end

   // Read data holds until the next read; ack alone marks fresh data
   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   // Fixed order A, B, C, D matches the pattern bit order
   // Pin packing
   assign pin_in_w[0] = pa_in;
   assign pin_in_w[1] = pb_in;
   assign pin_in_w[2] = pc_in;
   assign pin_in_w[3] = pd_in;
   assign pa_out = pin_out_w[0];
   assign pb_out = pin_out_w[1];
   assign pc_out = pin_out_w[2];
   assign pd_out = pin_out_w[3];
   assign pa_oe = pin_oe_w[0];
   assign pb_oe = pin_oe_w[1];
   assign pc_oe = pin_oe_w[2];
   assign pd_oe = pin_oe_w[3];

   // Each slice owns its synchroniser, so no raw pin reaches a decision
   // Port slices; pattern bit g gives the direction of port g
   for (genvar g = 0; g < `PDN_NUM_PORTS; g++) begin : g_port
      assign port_if[g].val = val_q[8*g +: 8];
      assign port_if[g].is_out = (dir_q[g] == `PDN_DIR_OUT);
      assign port_if[g].released = rel_q[g];
      assign sampled_w[g] = port_if[g].sampled;

      pdn_port_slice u_slice (
         .mclk(mclk),
         .rst(rst),
         .p(port_if[g]),
         .pin_in(pin_in_w[g]),
         .pin_out(pin_out_w[g]),
         .pin_oe(pin_oe_w[g])
      );
   end

   // Status comes straight from flops and settles one edge after a command
   // Outputs
   assign cmd_done = done_q;
   assign cmd_cd_forced = forced_q;
   assign rd_ack = ack_q;
   assign rd_data = rdat_q;
   assign port_dir = dir_q;
   assign port_released = rel_q;
   // Fast bus direction is only reported; its own logic lies elsewhere
   assign fast_dir = dir_q[`PDN_DIR_FAST_BIT];
endmodule

// ### tb/pdn_checker.sv
// Port-level assertions for the direction block
`timescale 1ns/1ps
module pdn_checker
   import pdn_pkg::*;
(
   input logic mclk,
   input logic rst,
   input logic cmd_valid,
   input logic [4:0] cmd_dir,
   input logic [31:0] cmd_init,
   input pdn_rel_e cmd_release,
   input logic cmd_done,
   input logic cmd_cd_forced,
   input logic [4:0] port_dir,
   input logic [3:0] port_released,
   input logic [7:0] pa_oe,
   input logic [7:0] pb_oe,
   input logic [7:0] pb_out
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Checked on the first edge after reset falls, when nothing is disabled
   a_reset_tristate: assert property (
      $fell(rst) |-> port_released == 4'h0 && port_dir == 5'h1F
         && pa_oe == 8'h00 && pb_oe == 8'h00)
      else $error("ports left released after reset");
   a_cd_opposite: assert property (
      cmd_valid |=> port_dir[2] != port_dir[3])
      else $error("C and D same way");
   a_forced_flag: assert property (
      cmd_valid |=> cmd_cd_forced == $past(~^cmd_dir[3:2]))
      else $error("forced flag wrong");
   a_cmd_done: assert property (
      cmd_done == $past(cmd_valid))
      else $error("done pulse wrong");
   a_dir_load: assert property (
      cmd_valid |=> port_dir[4:3] == $past(cmd_dir[4:3])
         && port_dir[1:0] == $past(cmd_dir[1:0]))
      else $error("direction not loaded");
   a_input_quiet: assert property (
      pa_oe != 8'h00 |-> port_released[0] && !port_dir[0])
      else $error("port A driven wrongly");
   a_out_value: assert property (
      cmd_valid && cmd_release == PDN_REL_ALL && !cmd_dir[1]
         |=> pb_oe == 8'hFF && pb_out == $past(cmd_init[15:8]))
      else $error("port B value wrong");
   a_release_group: assert property (
      port_released[3:1] == 3'h0 || port_released[3:1] == 3'h7)
      else $error("partial release");
endmodule
bind pdn_top pdn_checker u_chk (
   .mclk(mclk),
   .rst(rst),
   .cmd_valid(cmd_valid),
   .cmd_dir(cmd_dir),
   .cmd_init(cmd_init),
   .cmd_release(cmd_release),
   .cmd_done(cmd_done),
   .cmd_cd_forced(cmd_cd_forced),
   .port_dir(port_dir),
   .port_released(port_released),
   .pa_oe(pa_oe),
   .pb_oe(pb_oe),
   .pb_out(pb_out)
);

// ### tb/pdn_far_unit.sv
// Far unit on the cable, acting as direction master
`timescale 1ns/1ps
module pdn_far_unit #(
   parameter logic [4:0] PAT = 5'h16
) (
   // Clock and control
   input wire logic mclk,
   input wire logic go,
   // Near side drivers
   input wire logic [31:0] dut_oe,
   input wire logic [31:0] dut_out,
   // Resolved lines
   output logic [31:0] pin
);
   logic [31:0] f_oe = 32'h0;
   logic [31:0] f_val = 32'h0;
   // Pull-ups hold an undriven line high
   assign pin = (dut_oe & dut_out) | (~dut_oe & f_oe & f_val)
      | ~(dut_oe | f_oe);
   always @(posedge mclk) begin
      // Drive only after seeing an idle port A
      if (go && pin[7:0] == 8'hFF) begin
         f_oe <= {{8{~PAT[3]}}, {8{~PAT[2]}}, {8{~PAT[1]}}, 8'hFF};
         f_val <= {8'h5A, 16'hFFFF, 3'h3, PAT};
      end
   end
endmodule

// ### tb/pdn_top_tb_top.sv
// Self-checking bench for the direction block
`timescale 1ns/1ps
module pdn_top_tb_top;
   import pdn_pkg::*;
   localparam logic [4:0] PAT = 5'h16;
   logic mclk = 0, rst = 1, cmd_valid = 0, rd_valid = 0, rd_all = 1, go = 0;
   logic [4:0] cmd_dir = 5'h1F, port_dir, m_dir;
   logic [31:0] cmd_init = 0, rd_data, q, w;
   logic [7:0] exp_q[$];
   logic [1:0] rd_sel = 2'h0;
   logic [3:0] port_released, m_rel;
   logic cmd_done, cmd_cd_forced, rd_ack, fast_dir;
   pdn_rel_e cmd_release = PDN_REL_KEEP;
   wire [31:0] pin, oe, out;
   int mismatches = 0, compares = 0, cyc = 0, n, seed = 54250;
   always #20 mclk = ~mclk;
   pdn_top dut (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_dir(cmd_dir), .cmd_init(cmd_init), .cmd_release(cmd_release),
      .cmd_done(cmd_done), .cmd_cd_forced(cmd_cd_forced),
      .rd_valid(rd_valid), .rd_all(rd_all), .rd_sel(rd_sel), .rd_ack(rd_ack),
      .rd_data(rd_data), .port_dir(port_dir), .port_released(port_released),
      .fast_dir(fast_dir), .pa_in(pin[7:0]), .pa_out(out[7:0]),
      .pa_oe(oe[7:0]), .pb_in(pin[15:8]), .pb_out(out[15:8]),
      .pb_oe(oe[15:8]), .pc_in(pin[23:16]), .pc_out(out[23:16]),
      .pc_oe(oe[23:16]), .pd_in(pin[31:24]), .pd_out(out[31:24]),
      .pd_oe(oe[31:24]));
   pdn_far_unit #(.PAT(PAT)) far (.mclk(mclk), .go(go), .dut_oe(oe),
      .dut_out(out), .pin(pin));
   task chk(input logic [39:0] s, input logic [39:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task conclude;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task cmd(input logic [4:0] d, input logic [31:0] v, input pdn_rel_e r);
      logic [31:0] e, o;
      @(posedge mclk);
      cmd_valid <= 1;
      cmd_dir <= d;
      cmd_init <= v;
      cmd_release <= r;
      @(posedge mclk);
      cmd_valid <= 0;
      #1;
      m_dir = {d[4:3], ~d[3], d[1:0]};
      if (r == PDN_REL_NONE) m_rel = 4'h0;
      else if (r == PDN_REL_A_ONLY) m_rel = 4'h1;
      else if (r == PDN_REL_ALL) m_rel = 4'hF;
      for (int g = 0; g < 4; g++) begin
         o[g*8+:8] = m_dir[g] ? 8'h00 : 8'hFF;
         e[g*8+:8] = m_rel[g] ? o[g*8+:8] : 8'h00;
      end
      chk({cmd_done, cmd_cd_forced}, {1'b1, ~^d[3:2]});
      chk(port_dir, m_dir);
      chk({port_released, fast_dir}, {m_rel, d[4]});
      chk(oe, e);
      chk(out, o & v);
   endtask
   task rd(input logic a, input logic [1:0] s, output logic [31:0] r);
      @(posedge mclk);
      rd_valid <= 1;
      rd_all <= a;
      rd_sel <= s;
      @(posedge mclk);
      rd_valid <= 0;
      #1;
      r = rd_data;
      chk(rd_ack, 1'b1);
   endtask
   always @(posedge mclk) begin
      cyc++;
      // Bound covers reset, negotiation and the random run
      if (cyc > 3000) begin
         mismatches++;
         conclude;
      end
   end
   initial begin
      repeat (12) @(posedge mclk);
      rst <= 0;
      m_rel = 4'h0;
      #1 chk({port_released, oe}, 0);
      rd(1'b1, 2'h0, q);
      chk(q, 32'hFFFFFFFF);
      cmd(5'h1F, $random(seed), PDN_REL_A_ONLY);
      @(posedge mclk) go <= 1;
      n = 0;
      do begin
         rd(1'b1, 2'h0, q);
         chk(q[7] & (q[6:0] != 7'h7F), 1'b0);
         n++;
      end while (q[7] && n < 20);
      chk(n < 20, 1'b1);
      chk(q, {8'h5A, 16'hFFFF, 3'h3, PAT});
      chk({q[2] ^ q[3], q[0]}, 2'b10);
      w = $random(seed);
      cmd(~q[4:0], w, PDN_REL_ALL);
      // Line model: far unit holds A and D, our values stand on B and C
      exp_q.push_back({3'h3, PAT});
      exp_q.push_back(w[15:8]);
      exp_q.push_back(w[23:16]);
      exp_q.push_back(8'h5A);
      // Pins need the two sync stages before a read can see them
      repeat (2) @(posedge mclk);
      for (int s = 0; s < 4; s++) begin
         rd(1'b0, 2'(s), q);
         chk(q, {24'h00_0000, exp_q.pop_front()});
      end
      // Random commands reach every release code and C/D clash
      repeat (30) begin
         w = $random(seed);
         cmd(w[4:0], $random(seed), pdn_rel_e'(w[6:5]));
      end
      @(posedge mclk) rst <= 1;
      repeat (2) @(posedge mclk);
      rst <= 0;
      m_rel = 4'h0;
      #1 chk({port_released, oe}, 0);
      // First command right after reset, with C and D clashing
      cmd(5'h13, $random(seed), PDN_REL_ALL);
      conclude;
   end
endmodule
